// ---- verilog/ptq_pad_trigger_qualifier.sv ----
// Per-input drum trigger qualification with a Wishbone register port.
// Assumes classic Wishbone on clk_i and asynchronous sample buses from converters.
`timescale 1ns/1ps
`default_nettype none
module ptq_pad_trigger_qualifier
	import ptq_pkg::*;
#(
	parameter int TICK_CYC = PTQ_TICK_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [PTQ_NUM_CH*PTQ_SW-1:0] head_smp_i,
	input wire logic [PTQ_SW-1:0] rim_smp_i,
	output logic note_vld_o,
	output logic [2:0] note_ch_o,
	output logic [7:0] note_vel_o,
	output logic note_rim_o
);
	// ==========================================================
	// Input synchronisers
	logic [PTQ_NUM_CH*PTQ_SW-1:0] smp_s1_reg;
	logic [PTQ_NUM_CH*PTQ_SW-1:0] smp_s2_reg;
	logic [PTQ_SW-1:0] rim_s1_reg;
	logic [PTQ_SW-1:0] rim_s2_reg;
	// Sample buses arrive from converters on their own clock
	// Two stages before any logic looks at a sample
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			smp_s1_reg <= '0;
			smp_s2_reg <= '0;
			rim_s1_reg <= '0;
			rim_s2_reg <= '0;
		end else begin
			smp_s1_reg <= head_smp_i;
			smp_s2_reg <= smp_s1_reg;
			rim_s1_reg <= rim_smp_i;
			rim_s2_reg <= rim_s1_reg;
		end
	end
	// ==========================================================
	// 0.1 ms tick divider
	logic [15:0] tick_cnt_reg;
	logic tick_reg;
	// Every window counts these one-cycle ticks, never raw clocks
	// TICK_CYC may be shortened in simulation to keep runs brief
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tick_cnt_reg <= '0;
			tick_reg <= 1'b0;
		end else if (tick_cnt_reg == 16'(TICK_CYC - 1)) begin
			tick_cnt_reg <= '0;
			tick_reg <= 1'b1;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 16'h0001;
			tick_reg <= 1'b0;
		end
	end
	// ==========================================================
	// Register file
	logic [31:0] cfg_reg [PTQ_NUM_CH];
	logic [3:0] prof_reg [PTQ_NUM_CH];
	logic ack_reg;
	logic wb_req;
	logic [2:0] wb_ch;
	logic [31:0] wr_word;
	logic rim_ok_new;
	logic rim_avail;
	logic [PTQ_NUM_CH-1:0] busy_vec;
	// A held request is taken once; the cycle after ack it may be taken again
	assign wb_req = wb_cyc_i && wb_stb_i && !ack_reg;
	assign wb_ch = wb_adr_i[4:2];
	assign rim_avail = (prof_reg[PTQ_SNARE_CH] == PTQ_PROF_DUAL_A) || (prof_reg[PTQ_SNARE_CH] == PTQ_PROF_DUAL_B);
	assign rim_ok_new = (wb_ch == 3'(PTQ_SNARE_CH)) &&
		((wb_dat_i[3:0] == PTQ_PROF_DUAL_A) || (wb_dat_i[3:0] == PTQ_PROF_DUAL_B));
	// Byte-lane merge of a configuration write
	always_comb begin
		wr_word = cfg_reg[wb_ch];
		for (int b = 0; b < 4; b++) begin
			if (wb_sel_i[b]) begin
				wr_word[b*8 +: 8] = wb_dat_i[b*8 +: 8];
			end
		end
		if (!((wb_ch == 3'(PTQ_SNARE_CH)) && rim_avail)) begin
			wr_word[PTQ_RIM_LSB +: 4] = 4'h0;
		end
		// Out-of-range fields are clamped, not refused, so a read shows what is used
		if (wr_word[PTQ_SCAN_LSB +: 6] > PTQ_SCAN_MAX) begin
			wr_word[PTQ_SCAN_LSB +: 6] = PTQ_SCAN_MAX;
		end
		if (wr_word[PTQ_MASK_LSB +: 5] > PTQ_MASK_MAX) begin
			wr_word[PTQ_MASK_LSB +: 5] = PTQ_MASK_MAX;
		end
		if (wr_word[PTQ_XT_LSB +: 4] > PTQ_XT_MAX) begin
			wr_word[PTQ_XT_LSB +: 4] = PTQ_XT_MAX;
		end
	end
	// Configuration and profile storage; a profile write loads presets
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int c = 0; c < PTQ_NUM_CH; c++) begin
				cfg_reg[c] <= PTQ_CFG_RST;
				prof_reg[c] <= PTQ_PROF_RST;
			end
		end else if (wb_req && wb_we_i) begin
			if (wb_adr_i[7:5] == PTQ_CFG_BASE[7:5]) begin
				cfg_reg[wb_ch] <= wr_word & PTQ_CFG_WMASK;
			end else if (wb_adr_i[7:5] == PTQ_PROF_BASE[7:5] && wb_sel_i[0]) begin
				// Presets replace every field; the rim field survives only where available
				prof_reg[wb_ch] <= wb_dat_i[3:0];
				cfg_reg[wb_ch] <= ptq_preset(wb_dat_i[3:0]) &
					{rim_ok_new ? 4'hF : 4'h0, 28'hFFF_FFFF};
			end
		end
	end
	// Single-wait-state acknowledge and read data
	// Read data is zero outside the ack cycle so a stale word never leaks
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			ack_reg <= wb_req;
			if (wb_req && !wb_we_i) begin
				if (wb_adr_i[7:5] == PTQ_CFG_BASE[7:5]) begin
					wb_dat_o <= cfg_reg[wb_ch];
				end else if (wb_adr_i[7:5] == PTQ_PROF_BASE[7:5]) begin
					wb_dat_o <= {28'h000_0000, prof_reg[wb_ch]};
				end else if (wb_adr_i == PTQ_STAT_OFS) begin
					wb_dat_o <= {23'h00_0000, rim_avail, busy_vec};
				end else begin
					wb_dat_o <= '0;
				end
			end else begin
				wb_dat_o <= '0;
			end
		end
	end
	assign wb_ack_o = ack_reg;
	// ==========================================================
	// Shared crosstalk memory and arbitration
	logic [PTQ_NUM_CH-1:0] commit_vec;
	logic [PTQ_NUM_CH-1:0] grant_vec;
	logic [PTQ_NUM_CH*8-1:0] act_peak_flat;
	logic [PTQ_NUM_CH*8-1:0] peak_flat;
	logic [PTQ_NUM_CH*8-1:0] vel_flat;
	logic [PTQ_NUM_CH-1:0] rim_vec;
	logic [7:0] xt_peak_reg;
	logic [2:0] xt_src_reg;
	logic [2:0] g_idx;
	logic [7:0] g_peak;
	// Lowest committing index wins; the others wait in COMMIT until no lower index is committing
	assign grant_vec = commit_vec & (~commit_vec + PTQ_NUM_CH'(1));
	// Index and peak of the granted channel
	always_comb begin
		g_idx = 3'h0;
		g_peak = 8'h00;
		for (int c = 0; c < PTQ_NUM_CH; c++) begin
			if (grant_vec[c]) begin
				g_idx = 3'(c);
				g_peak = peak_flat[c*8 +: 8];
			end
		end
	end
	// Strongest recent hit, decaying one step per tick
	// A softer hit does not displace a louder one still ringing out
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			xt_peak_reg <= 8'h00;
			xt_src_reg <= 3'h0;
		end else if (|grant_vec && g_peak >= xt_peak_reg) begin
			xt_peak_reg <= g_peak;
			xt_src_reg <= g_idx;
		end else if (tick_reg && xt_peak_reg != 8'h00) begin
			xt_peak_reg <= xt_peak_reg - 8'h01;
		end
	end
	// Note event output, one channel per cycle
	// Fields hold between notes; only the valid bit pulses
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			note_vld_o <= 1'b0;
			note_ch_o <= 3'h0;
			note_vel_o <= 8'h00;
			note_rim_o <= 1'b0;
		end else begin
			note_vld_o <= |grant_vec;
			if (|grant_vec) begin
				note_ch_o <= g_idx;
				note_vel_o <= vel_flat[g_idx*8 +: 8];
				note_rim_o <= rim_vec[g_idx];
			end
		end
	end
	// ==========================================================
	// Per-channel qualifiers
	// One copy per input; only input 2 ever sees rim samples
	genvar g;
	generate
		for (g = 0; g < PTQ_NUM_CH; g++) begin : g_ch
			ptq_state_t st_reg;
			logic [7:0] peak_reg;
			logic [7:0] rpeak_reg;
			logic [7:0] env_reg;
			logic [5:0] scan_cnt_reg;
			logic [9:0] mask_cnt_reg;
			logic [7:0] h_lvl;
			logic [7:0] r_lvl;
			logic [7:0] lvl;
			logic [7:0] other;
			logic [4:0] env_step;
			logic [12:0] own_x;
			logic [12:0] oth_x;
			logic [12:0] vel_x;
			logic dual;
			logic start;
			logic drop;
			// Only second-stage synchroniser outputs reach the qualifier
			assign dual = (g == PTQ_SNARE_CH) && rim_avail;
			assign h_lvl = smp_s2_reg[g*8 +: 8];
			assign r_lvl = dual ? rim_s2_reg : 8'h00;
			// Either zone triggers with the same parameters
			assign lvl = (r_lvl > h_lvl) ? r_lvl : h_lvl;
			assign start = (lvl > {cfg_reg[g][PTQ_THR_LSB +: 4], 4'h0}) &&
				(lvl > env_reg);
			// Higher rejection strength gives a slower envelope decay, so fast rolls may drop
			assign env_step = 5'h10 - {1'b0, cfg_reg[g][PTQ_RTG_LSB +: 4]};
			// Loudest competing hit from other inputs
			always_comb begin
				other = (xt_src_reg != 3'(g)) ? xt_peak_reg : 8'h00;
				for (int j = 0; j < PTQ_NUM_CH; j++) begin
					if (j != g && act_peak_flat[j*8 +: 8] > other) begin
						other = act_peak_flat[j*8 +: 8];
					end
				end
			end
			// Own*20 against other*(level+3), i.e. other*(level+3)*5 percent
			assign own_x = {peak_reg, 4'h0} + {2'b00, peak_reg, 2'b00};
			assign oth_x = other * (5'(cfg_reg[g][PTQ_XT_LSB +: 4]) + 5'h03);
			// Level zero means OFF: the crosstalk test is skipped entirely
			assign drop = (cfg_reg[g][PTQ_XT_LSB +: 4] != 4'h0) && (own_x < oth_x);
			// Velocity saturates at full scale instead of wrapping
			assign vel_x = peak_reg * (5'(cfg_reg[g][PTQ_SENS_LSB +: 4]) + 5'h01);
			assign vel_flat[g*8 +: 8] = (vel_x[12] ? 8'hFF : vel_x[11:4]);
			// Rim wins when its peak scaled by sensitivity reaches eight times the louder zone's peak
			// Equal weighting at sensitivity 8; higher settings favour the rim
			assign rim_vec[g] = dual && (cfg_reg[g][PTQ_RIM_LSB +: 4] != 4'h0) &&
				((rpeak_reg * cfg_reg[g][PTQ_RIM_LSB +: 4]) >= {1'b0, peak_reg, 3'h0});
			// Arbitration and status views of the sequencer
			assign commit_vec[g] = (st_reg == PTQ_COMMIT);
			assign busy_vec[g] = (st_reg != PTQ_IDLE);
			assign peak_flat[g*8 +: 8] = peak_reg;
			// Only hits still being measured or waiting in COMMIT count as live crosstalk sources
			assign act_peak_flat[g*8 +: 8] = (st_reg == PTQ_SCAN || st_reg == PTQ_COMMIT) ? peak_reg : 8'h00;
			// Channel sequencer: detect, scan, commit, hold off
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					st_reg <= PTQ_IDLE;
					peak_reg <= 8'h00;
					rpeak_reg <= 8'h00;
					scan_cnt_reg <= 6'h00;
					mask_cnt_reg <= 10'h000;
				end else begin
					case (st_reg)
						// Threshold and envelope both gate a new hit
						PTQ_IDLE: begin
							if (start) begin
								st_reg <= PTQ_SCAN;
								peak_reg <= lvl;
								rpeak_reg <= r_lvl;
								scan_cnt_reg <= cfg_reg[g][PTQ_SCAN_LSB +: 6];
							end
						end
						PTQ_SCAN: begin
							if (lvl > peak_reg) begin
								peak_reg <= lvl;
							end
							if (r_lvl > rpeak_reg) begin
								rpeak_reg <= r_lvl;
							end
							// Drop decision uses the peak held so far, not this cycle's sample
							if (scan_cnt_reg == 6'h00) begin
								st_reg <= drop ? PTQ_IDLE : PTQ_COMMIT;
							end else if (tick_reg) begin
								scan_cnt_reg <= scan_cnt_reg - 6'h01;
							end
						end
						// Hold-off starts only when the note is actually emitted
						PTQ_COMMIT: begin
							if (grant_vec[g]) begin
								st_reg <= PTQ_MASK;
								mask_cnt_reg <= 10'(cfg_reg[g][PTQ_MASK_LSB +: 5] * PTQ_MASK_TICKS);
							end
						end
						// Triggers arriving now are ignored; the level is not even compared
						PTQ_MASK: begin
							if (mask_cnt_reg == 10'h000) begin
								st_reg <= PTQ_IDLE;
							end else if (tick_reg) begin
								mask_cnt_reg <= mask_cnt_reg - 10'h001;
							end
						end
						default: st_reg <= PTQ_IDLE;
					endcase
				end
			end
			// Decaying envelope of the last accepted hit
			// Restarting from the emitted peak refuses rebounds below it
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					env_reg <= 8'h00;
				end else if (st_reg == PTQ_COMMIT && grant_vec[g]) begin
					env_reg <= peak_reg;
				end else if (tick_reg) begin
					env_reg <= ({3'h0, env_reg} > 11'(env_step)) ? env_reg - 8'(env_step) : 8'h00;
				end
			end
		end
	endgenerate
endmodule : ptq_pad_trigger_qualifier
`default_nettype wire

// ---- verilog/ptq_pkg.sv ----
// Constants, field layout and presets for the pad trigger qualifier.
// Assumes a 250 MHz system clock and 8-bit digitised trigger levels.
package ptq_pkg;
	// ==========================================================
	// Sizes
	localparam int PTQ_NUM_CH = 8;
	localparam int PTQ_SW = 8;
	localparam int PTQ_SNARE_CH = 1; // Trigger input 2
	// ==========================================================
	// Timing
	localparam int PTQ_CLK_NS = 4;
	localparam int PTQ_SCAN_STEP_US = 100; // 0.1 ms
	localparam int PTQ_MASK_STEP_MS = 4;
	localparam int PTQ_TICK_CYC = PTQ_SCAN_STEP_US * 1000 / PTQ_CLK_NS;
	localparam logic [9:0] PTQ_MASK_TICKS = 10'(PTQ_MASK_STEP_MS * 1000 / PTQ_SCAN_STEP_US);
	localparam logic [5:0] PTQ_SCAN_MAX = 6'h28; // 4.0 ms
	localparam logic [4:0] PTQ_MASK_MAX = 5'h10; // 64 ms
	localparam logic [3:0] PTQ_XT_MAX = 4'hD; // Level 13, 80 percent
	// ==========================================================
	// Register offsets (byte addresses)
	localparam logic [7:0] PTQ_CFG_BASE = 8'h00;
	localparam logic [7:0] PTQ_PROF_BASE = 8'h40;
	localparam logic [7:0] PTQ_STAT_OFS = 8'h80;
	// ==========================================================
	// Configuration word fields
	localparam int PTQ_THR_LSB = 0;
	localparam int PTQ_SENS_LSB = 4;
	localparam int PTQ_SCAN_LSB = 8;
	localparam int PTQ_MASK_LSB = 14;
	localparam int PTQ_RTG_LSB = 20;
	localparam int PTQ_XT_LSB = 24;
	localparam int PTQ_RIM_LSB = 28;
	localparam logic [31:0] PTQ_CFG_RST = 32'h0040_9470;
	localparam logic [31:0] PTQ_CFG_WMASK = 32'hFFFF_FFFF;
	// ==========================================================
	// Pad profiles
	localparam logic [3:0] PTQ_PROF_RST = 4'h1;
	localparam logic [3:0] PTQ_PROF_DUAL_A = 4'h3;
	localparam logic [3:0] PTQ_PROF_DUAL_B = 4'h4;
	localparam logic [3:0] PTQ_PROF_SLOW_A = 4'h9;
	localparam logic [3:0] PTQ_PROF_SLOW_B = 4'hA;
	localparam logic [3:0] PTQ_PROF_ACOUSTIC = 4'hB;
	// Channel states
	typedef enum logic [1:0] {
		PTQ_IDLE = 2'b00,
		PTQ_SCAN = 2'b01,
		PTQ_COMMIT = 2'b10,
		PTQ_MASK = 2'b11
	} ptq_state_t;
	// Preset configuration loaded when a profile is chosen
	function automatic logic [31:0] ptq_preset(input logic [3:0] prof);
		logic [31:0] c;
		c = PTQ_CFG_RST;
		case (prof)
			PTQ_PROF_DUAL_A: c = 32'h8040_9470;
			PTQ_PROF_DUAL_B: c = 32'h8040_9880;
			PTQ_PROF_SLOW_A: c = 32'h0040_A880;
			PTQ_PROF_SLOW_B: c = 32'h0060_A880;
			PTQ_PROF_ACOUSTIC: c = 32'h0080_C870;
			default: c = PTQ_CFG_RST;
		endcase
		return c;
	endfunction : ptq_preset
endpackage : ptq_pkg

// ---- bench/ptq_checker.sv ----
// Port-level assertions for the pad trigger qualifier.
// Assumes binding onto the top module; one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module ptq_checker
	import ptq_pkg::*;
#(
	parameter int TICK_CYC = 10
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic [63:0] head_smp_i,
	input wire logic [7:0] rim_smp_i,
	input wire logic note_vld_o,
	input wire logic [2:0] note_ch_o,
	input wire logic [7:0] note_vel_o,
	input wire logic note_rim_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ==========================================
	// Cycles since any head or rim level was nonzero; a rim-only strike is a hit too
	logic [31:0] quiet_reg;
	always_ff @(posedge clk_i) begin
		if (rst_i || head_smp_i != 64'h0 || rim_smp_i != 8'h0) quiet_reg <= 32'h0;
		else if (quiet_reg != 32'hFFFF_FFFF) quiet_reg <= quiet_reg + 32'h1;
	end
	// ==========================================
	// Bus and note assertions
	ack_timing_a: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o) else $error("ack late");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack unasked");
	dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
	rim_input_a: assert property (note_vld_o && note_rim_o |-> note_ch_o == 3'(PTQ_SNARE_CH)) else $error("rim off input 2");
	one_note_a: assert property (note_vld_o |=> !(note_vld_o && note_ch_o == $past(note_ch_o))) else $error("double note");
	note_hold_a: assert property (!note_vld_o |-> $stable({note_ch_o, note_vel_o, note_rim_o})) else $error("note fields moved");
	note_cause_a: assert property (note_vld_o |-> quiet_reg <= 32'(50 * TICK_CYC)) else $error("note without hit");
endmodule : ptq_checker
bind ptq_pad_trigger_qualifier ptq_checker #(.TICK_CYC(TICK_CYC)) i_ptq_checker (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .head_smp_i(head_smp_i),
	.rim_smp_i(rim_smp_i),
	.note_vld_o(note_vld_o), .note_ch_o(note_ch_o), .note_vel_o(note_vel_o), .note_rim_o(note_rim_o));
`default_nettype wire

// ---- bench/ptq_pad_model.sv ----
// Pad model: a strike sets a head (and rim) level that then decays.
// Assumes strike commands from the bench, synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module ptq_pad_model (
	input wire logic clk_i,
	input wire logic hit_i,
	input wire logic [2:0] ch_i,
	input wire logic [7:0] lvl_i,
	input wire logic [7:0] rim_i,
	output logic [63:0] head_smp_o = 64'h0,
	output logic [7:0] rim_smp_o = 8'h0
);
	// ==========================================
	// Decay by a quarter plus one each cycle, like a piezo ringing out
	always_ff @(posedge clk_i) begin
		logic [7:0] l;
		for (int c = 0; c < 8; c++) begin
			l = head_smp_o[c*8+:8];
			if (hit_i && ch_i == 3'(c)) head_smp_o[c*8+:8] <= lvl_i;
			else head_smp_o[c*8+:8] <= l - (l >> 2) - 8'(l != 8'h0);
		end
		if (hit_i && ch_i == 3'h1) rim_smp_o <= rim_i;
		else rim_smp_o <= rim_smp_o - (rim_smp_o >> 2) - 8'(rim_smp_o != 8'h0);
	end
endmodule : ptq_pad_model
`default_nettype wire

// ---- bench/ptq_pad_trigger_qualifier_tb_top.sv ----
// Self-checking bench: registers over Wishbone, strikes through the pad model.
// Assumes the checker is bound; tick shortened to 10 cycles.
`timescale 1ns/1ps
`default_nettype none
module ptq_pad_trigger_qualifier_tb_top;
	import ptq_pkg::*;
	logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, hit = 0, note_vld, note_rim, ack;
	logic [7:0] adr = 8'h0, lvl = 8'h0, rim = 8'h0, vel_o, rim_smp;
	logic [31:0] dat = 32'h0, dat_o, q, seed = 32'h49D8;
	logic [3:0] sel = 4'h0;
	logic [2:0] ch = 3'h0, note_ch;
	logic [63:0] head;
	logic [11:0] notes[$];
	int err_total = 0, check_count = 0, t, s, l;
	logic [3:0] prof[5] = '{4'h3, 4'h4, 4'h9, 4'hA, 4'hB};
	logic [31:0] pre[5] = '{32'h8040_9470, 32'h8040_9880, 32'h0040_A880, 32'h0060_A880, 32'h0080_C870};
	always #2 clk_i = ~clk_i;
	ptq_pad_trigger_qualifier #(.TICK_CYC(10)) i_ptq_pad_trigger_qualifier (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
		.wb_dat_o(dat_o), .wb_ack_o(ack), .head_smp_i(head), .rim_smp_i(rim_smp), .note_vld_o(note_vld),
		.note_ch_o(note_ch), .note_vel_o(vel_o), .note_rim_o(note_rim));
	ptq_pad_model i_ptq_pad_model (.clk_i(clk_i), .hit_i(hit), .ch_i(ch), .lvl_i(lvl), .rim_i(rim),
		.head_smp_o(head), .rim_smp_o(rim_smp));
	// ==========================================
	// Note collector and helpers
	always @(posedge clk_i) if (note_vld === 1'b1) notes.push_back({note_rim, note_ch, vel_o});
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	function automatic logic [7:0] vel(int p, int sf);
		int v = (p * (sf + 1)) >> 4;
		return (v > 255) ? 8'hFF : 8'(v);
	endfunction : vel
	function automatic logic [31:0] cfg(int th, int sf, int sc, int mk, int xt);
		return 32'(th | (sf << 4) | (sc << 8) | (mk << 14) | (xt << 24));
	endfunction : cfg
	task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", n, exp, got);
		end
	endtask : chk
	task results();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : results
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		{cyc, we, adr, dat, sel} <= {1'b1, w, a, d, 4'hF};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (ack !== 1'b1) begin
			err_total++; // Bus timeout counts as a mismatch
			results();
		end
		q = dat_o;
		cyc <= 0;
	endtask : wb
	task strike(input int c, input int lv, input int rv, input int w);
		@(posedge clk_i);
		{hit, ch, lvl, rim} <= {1'b1, 3'(c), 8'(lv), 8'(rv)};
		@(posedge clk_i);
		hit <= 0;
		repeat (w) @(posedge clk_i);
	endtask : strike
	task nchk(input int n, input logic [11:0] e);
		chk("note_count", 32'(notes.size()), 32'(n));
		if (n > 0 && notes.size() > 0) chk("note", 32'(notes[0]), 32'(e));
		notes.delete();
	endtask : nchk
	initial begin
		repeat (100000) @(posedge clk_i);
		err_total++;
		results();
	end
	// ==========================================
	// Main sequence
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 0;
		wb(0, 8'h00, 0); chk("cfg_rst", q, 32'h0040_9470);
		wb(0, 8'h80, 0); chk("status_rst", q, 32'h0);
		wb(1, 8'hFC, 32'hFFFF_FFFF); wb(0, 8'hFC, 0); chk("unmapped", q, 32'h0);
		// All ones on a single-zone input: fields clamp and the rim field reads unavailable
		wb(1, 8'h00, 32'hFFFF_FFFF);
		wb(0, 8'h00, 0);
		chk("cfg_clamp", q, {4'h0, PTQ_XT_MAX, 4'hF, 1'b1, PTQ_MASK_MAX, PTQ_SCAN_MAX, 8'hFF});
		for (int i = 0; i < 5; i++) for (int c = 0; c < 2; c++) begin
			wb(1, 8'(8'h40 + 4 * c), 32'(prof[i]));
			wb(0, 8'(4 * c), 0);
			chk("preset", q, (c == 1 && i < 2) ? pre[i] : pre[i] & 32'h0FFF_FFFF);
		end
		// Threshold boundary then random levels and sensitivities
		for (int i = 0; i < 8; i++) begin
			t = rnd() % 16; s = rnd() % 16; l = (i < 2) ? t * 16 + i : rnd() % 256;
			wb(1, 8'h00, cfg(t, s, 0, 0, 0));
			strike(0, l, 0, 300);
			nchk((l > t * 16) ? 1 : 0, {4'h0, vel(l, s)});
		end
		// Scan window delays the note: none after 40 cycles, one after 300
		wb(1, 8'h00, cfg(0, 15, 5, 0, 0));
		strike(0, 150, 0, 40);
		nchk(0, 0);
		repeat (260) @(posedge clk_i);
		nchk(1, {4'h0, 8'd150});
		// Hold-off of one step: second strike hidden, third heard
		wb(1, 8'h00, cfg(0, 15, 0, 1, 0));
		strike(0, 100, 0, 300); nchk(1, {4'h0, 8'd100});
		strike(0, 200, 0, 300); nchk(0, 0);
		strike(0, 200, 0, 300); nchk(1, {4'h0, 8'd200});
		// Near-simultaneous strikes, weaker input first unprotected then protected
		wb(1, 8'h08, cfg(0, 15, 5, 0, 0));
		for (int x = 0; x < 14; x += 13) begin
			wb(1, 8'h0C, cfg(0, 15, 5, 0, x));
			strike(2, 200, 0, 0); strike(3, 40, 0, 300);
			nchk((x == 0) ? 2 : 1, {4'h2, 8'd200});
		end
		// Rim detection on input 2 with a dual-zone profile
		wb(1, 8'h44, 32'h3);
		wb(1, 8'h04, cfg(0, 15, 0, 0, 0) | 32'h8000_0000);
		wb(0, 8'h80, 0); chk("status_rim", q, 32'h100);
		// Velocity is the louder zone's peak on a dual-zone input
		strike(1, 80, 100, 300); nchk(1, {4'h9, 8'd100});
		wb(1, 8'h04, cfg(0, 15, 0, 0, 0));
		strike(1, 80, 100, 300); nchk(1, {4'h1, 8'd100});
		// Rim zone alone must clear the same threshold as the head
		wb(1, 8'h04, cfg(5, 15, 0, 0, 0));
		strike(1, 0, 60, 300);
		nchk(0, 0);
		strike(1, 0, 100, 300);
		nchk(1, {4'h1, 8'd100});
		// Slow envelope decay hides a softer rebound, a harder hit still passes
		wb(1, 8'h10, cfg(0, 15, 0, 0, 0) | 32'h00F0_0000);
		strike(4, 100, 0, 300);
		nchk(1, {4'h4, 8'd100});
		strike(4, 60, 0, 300);
		nchk(0, 0);
		strike(4, 200, 0, 300);
		nchk(1, {4'h4, 8'd200});
		results();
	end
endmodule : ptq_pad_trigger_qualifier_tb_top
`default_nettype wire
